// ===== pin_model.sv
// Behavioural model of the gate, event and trigger pins driven from outside the timer unit
module pin_model (
   input wire logic clk,
   output logic [5:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;

   initial pins = 6'h00;

   // Each level stands 24 clocks so the once-per-12 sampler sees it twice
   task automatic hold(input int idx, input logic v);
      @(posedge clk);
      pins[idx] <= v;
      repeat (24) @(posedge clk);
   endtask : hold

   task automatic fall(input int idx);
      hold(idx, 1'b1);
      hold(idx, 1'b0);
   endtask : fall
endmodule : pin_model

// ===== tb.sv
// Self-checking bench for the three timer/counter unit
`include "timer_unit_map.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic reset = 1'b1;
   logic ack0 = 1'b0;
   logic ack1 = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid, ovf0, ovf1, irq2, u1rx, u1tx, u2rx, u2tx;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [5:0] pins;
   wire [2:0] flags = {irq2, ovf1, ovf0};
   logic [31:0] rd_data;
   logic [1:0] rs;
   logic [1:0] ws;
   int errors = 0;
   int num_checks = 0;
   int n, n_rx, n_tx, n_tx2;

   three_timer_counter_unit three_timer_counter_unit_i (
      .clk(clk), .reset(reset), .ext_irq0_pin(pins[`PIN_IRQ0]), .ext_irq1_pin(pins[`PIN_IRQ1]),
      .tmr0_event_pin(pins[`PIN_EV0]), .tmr1_event_pin(pins[`PIN_EV1]),
      .tmr2_event_pin(pins[`PIN_EV2]), .tmr2_trigger_pin(pins[`PIN_TRIG]),
      .tmr0_vector_ack(ack0), .tmr1_vector_ack(ack1), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .tmr0_overflow_flag(ovf0), .tmr1_overflow_flag(ovf1), .tmr2_irq(irq2),
      .uart1_rx_baud(u1rx), .uart1_tx_baud(u1tx), .uart2_rx_baud(u2rx), .uart2_tx_baud(u2tx)
   );
   pin_model pin_model_i (.clk(clk), .pins(pins));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      if (u1tx === 1'b1) n_tx++;
      if (u2tx === 1'b1) n_tx2++;
      if (u1rx === 1'b1 || u2rx === 1'b1) n_rx++;
   end

   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task timeout;
      chk(32'h0, 32'h1);
      finish_test();
   endtask : timeout

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         k++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && k < 50);
      ws = bresp;
      bready <= 1'b0;
      if (k >= 50) timeout();
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int k;
      k = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         k++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && k < 50);
      rd_data = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (k >= 50) timeout();
   endtask : rd

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rd_data, e);
   endtask : rchk

   // Counts clocks until the chosen flag is seen high
   task automatic wait_hi(input int which);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (flags[which] !== 1'b1 && n < 1000);
      if (n >= 1000) timeout();
   endtask : wait_hi

   task automatic ack_pulse(input int which);
      @(posedge clk);
      if (which == 0) ack0 <= 1'b1; else ack1 <= 1'b1;
      @(posedge clk);
      ack0 <= 1'b0;
      ack1 <= 1'b0;
      @(posedge clk);
   endtask : ack_pulse

   task test_reset;
      rchk(`OFF_MODE, 32'h0);
      rchk(`OFF_T2CTL, 32'h0);
      rchk(`OFF_RUN, 32'h0);
      rd(8'h20);
      chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
      wr(8'h20, 32'h0);
      chk({30'h0, ws}, {30'h0, `RESP_SLVERR});
      $display("test reset done");
   endtask : test_reset

   task test_timer01;
      wr(`OFF_TMR0, 32'hfff0);
      wr(`OFF_MODE, 32'h01);
      wr(`OFF_RUN, 32'h1);
      wait_hi(0);
      chk(32'(n >= 170 && n <= 200), 32'h1);
      ack_pulse(0);
      chk({31'h0, ovf0}, 32'h0);
      wr(`OFF_RUN, 32'h0);
      wr(`OFF_TMR1, 32'hf0fe);
      wr(`OFF_MODE, 32'h20);
      wr(`OFF_RUN, 32'h2);
      wait_hi(1);
      ack_pulse(1);
      wait_hi(1);
      // Reload from 0xf0 gives sixteen machine cycles between overflows
      chk(32'(n >= 180 && n <= 195), 32'h1);
      wr(`OFF_RUN, 32'h0);
      rd(`OFF_TMR1);
      chk({24'h0, rd_data[15:8]}, 32'hf0);
      // 13-bit mode: carry after two cycles, overflow after thirty-four
      wr(`OFF_TMR0, 32'hfefe);
      wr(`OFF_MODE, 32'h00);
      wr(`OFF_RUN, 32'h1);
      wait_hi(0);
      chk(32'(n >= 396 && n <= 407), 32'h1);
      wr(`OFF_RUN, 32'h0);
      rchk(`OFF_TMR0, 32'h00e0);
      $display("test timer01 done");
   endtask : test_timer01

   task test_gate_count;
      wr(`OFF_TMR0, 32'h0);
      wr(`OFF_MODE, 32'h09);
      wr(`OFF_RUN, 32'h1);
      repeat (60) @(posedge clk);
      rchk(`OFF_TMR0, 32'h0);
      pin_model_i.hold(`PIN_IRQ0, 1'b1);
      repeat (60) @(posedge clk);
      rd(`OFF_TMR0);
      chk(32'(rd_data != 32'h0), 32'h1);
      wr(`OFF_RUN, 32'h0);
      wr(`OFF_TMR0, 32'h0);
      wr(`OFF_MODE, 32'h05);
      wr(`OFF_RUN, 32'h1);
      repeat (3) pin_model_i.fall(`PIN_EV0);
      repeat (36) @(posedge clk);
      wr(`OFF_RUN, 32'h0);
      rchk(`OFF_TMR0, 32'h3);
      $display("test gate and count done");
   endtask : test_gate_count

   task test_split;
      wr(`OFF_TMR1, 32'h1000);
      wr(`OFF_TMR0, 32'h0);
      wr(`OFF_MODE, 32'h33);
      wr(`OFF_RUN, 32'h2);
      repeat (60) @(posedge clk);
      rchk(`OFF_TMR1, 32'h1000);
      rd(`OFF_TMR0);
      chk({24'h0, rd_data[7:0]}, 32'h0);
      chk(32'(rd_data[15:8] != 8'h0), 32'h1);
      ack_pulse(1);
      n_rx = 0;
      wr(`OFF_TMR1, 32'hf0fe);
      wr(`OFF_MODE, 32'h23);
      repeat (250) @(posedge clk);
      chk(32'(n_rx >= 2), 32'h1);
      chk({31'h0, ovf1}, 32'h0);
      wr(`OFF_RUN, 32'h0);
      $display("test split done");
   endtask : test_split

   task test_t2_trigger;
      wr(`OFF_TMR2, 32'h1234);
      wr(`OFF_T2CTL, 32'h0f);
      pin_model_i.fall(`PIN_TRIG);
      rchk(`OFF_CAP, 32'h1234);
      rchk(`OFF_T2CTL, 32'h4f);
      chk({31'h0, irq2}, 32'h1);
      pin_model_i.fall(`PIN_EV2);
      rchk(`OFF_TMR2, 32'h1235);
      wr(`OFF_CAP, 32'habcd);
      wr(`OFF_TMR2, 32'h0011);
      wr(`OFF_T2CTL, 32'h0e);
      pin_model_i.fall(`PIN_TRIG);
      rchk(`OFF_TMR2, 32'habcd);
      rchk(`OFF_T2CTL, 32'h4e);
      wr(`OFF_T2CTL, 32'h0);
      $display("test t2 trigger done");
   endtask : test_t2_trigger

   task test_t2_overflow;
      for (int i = 0; i < 2; i++) begin
         wr(`OFF_CAP, 32'hfff0);
         wr(`OFF_TMR2, 32'hfffe);
         wr(`OFF_T2CTL, 32'h04 | i);
         wait_hi(2);
         rchk(`OFF_T2CTL, 32'h84 | i);
         wr(`OFF_T2CTL, 32'h0);
         rd(`OFF_TMR2);
         chk({20'h0, rd_data[15:4]}, (i == 0) ? 32'hfff : 32'h0);
      end
      $display("test t2 overflow done");
   endtask : test_t2_overflow

   task test_baud;
      wr(`OFF_POWER_CONTROL_REG, 32'h2);
      wr(`OFF_CAP, 32'hfff8);
      wr(`OFF_TMR2, 32'hfff8);
      n_tx = 0;
      n_tx2 = 0;
      n_rx = 0;
      wr(`OFF_T2CTL, 32'h1c);
      repeat (300) @(posedge clk);
      rchk(`OFF_T2CTL, 32'h1c);
      pin_model_i.fall(`PIN_TRIG);
      rd(`OFF_T2CTL);
      chk({24'h0, rd_data[7:0]}, 32'h5c);
      wr(`OFF_T2CTL, 32'h0);
      chk(32'(n_tx >= 3), 32'h1);
      chk(32'(n_tx2 >= 3), 32'h1);
      chk(n_rx, 32'h0);
      $display("test baud done");
   endtask : test_baud

   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      test_reset();
      test_timer01();
      test_gate_count();
      test_split();
      test_t2_trigger();
      test_t2_overflow();
      test_baud();
      finish_test();
   end
endmodule : tb

// ===== three_timer_counter_unit.sv
// Three timer/counters with an AXI4-Lite register slave
`include "timer_unit_map.svh"

module three_timer_counter_unit (
   input wire logic clk,
   input wire logic reset,
   input wire logic ext_irq0_pin,
   input wire logic ext_irq1_pin,
   input wire logic tmr0_event_pin,
   input wire logic tmr1_event_pin,
   input wire logic tmr2_event_pin,
   input wire logic tmr2_trigger_pin,
   input wire logic tmr0_vector_ack,
   input wire logic tmr1_vector_ack,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic tmr0_overflow_flag,
   output logic tmr1_overflow_flag,
   output logic tmr2_irq,
   output logic uart1_rx_baud,
   output logic uart1_tx_baud,
   output logic uart2_rx_baud,
   output logic uart2_tx_baud
);
   timer_unit_pkg::state_t st;
   timer_unit_pkg::state_t next_st;
   timer_unit_pkg::step_t r0;
   timer_unit_pkg::step_t r1;
   logic [`NPINS-1:0] pins;
   logic [`NPINS-1:0] fall;
   logic tick;
   logic [1:0] mode0;
   logic [1:0] mode1;
   logic inc0;
   logic inc1;
   logic split_carry;
   logic t1_ovf;
   logic set_tf0;
   logic set_tf1;
   logic baud_mode;
   logic inc2;
   logic ovf2;
   logic trig;
   logic sw_wr;
   logic sw_rd;
   logic [7:0] t2c;

   assign pins = {tmr2_trigger_pin, tmr2_event_pin, tmr1_event_pin, tmr0_event_pin,
                  ext_irq1_pin, ext_irq0_pin};

   // One machine-cycle step of a timer in modes 0 to 2; mode 3 holds
   function automatic timer_unit_pkg::step_t step(input logic [1:0] mode, input logic [7:0] low,
                                                  input logic [7:0] high, input logic inc);
      timer_unit_pkg::step_t r;
      r.low = low;
      r.high = high;
      r.ovf = 1'b0;
      if (inc) begin
         case (mode)
            `MODE_13BIT: begin
               // Upper three low-byte bits are left as they are
               r.low[`PRESC_MSB:0] = low[`PRESC_MSB:0] + 5'h01;
               if (low[`PRESC_MSB:0] == `PRESC_FULL) begin
                  {r.ovf, r.high} = {1'b0, high} + 9'h001;
               end
            end
            `MODE_16BIT: begin
               {r.ovf, r.high, r.low} = {1'b0, high, low} + 17'h00001;
            end
            `MODE_RELOAD8: begin
               if (low == `BYTE_FULL) begin
                  r.low = high;
                  r.ovf = 1'b1;
               end else begin
                  r.low = low + 8'h01;
               end
            end
            default: begin
               r.ovf = 1'b0;
            end
         endcase
      end
      return r;
   endfunction : step

   always_comb begin
      next_st = st;
      next_st.awready = 1'b0;
      next_st.wready = 1'b0;
      next_st.arready = 1'b0;
      next_st.baud = 4'h0;
      split_carry = 1'b0;
      // Pins: third and second stage must agree before the level moves
      next_st.sync1 = pins;
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      next_st.level = (st.sync2 & st.sync3) | ((st.sync2 ^ st.sync3) & st.level);
      tick = st.prescale == `MC_LAST;
      next_st.prescale = tick ? 4'h0 : st.prescale + 4'h1;
      // Pins are looked at once per machine cycle, so an edge needs two of them
      fall = tick ? (st.sample & ~st.level) : '0;
      if (tick) begin
         next_st.sample = st.level;
      end

      // Timer 0
      mode0 = st.timer01_mode_select[`MS_MODE0];
      inc0 = st.tmr0_run & (~st.timer01_mode_select[`MS_GATE0] | st.level[`PIN_IRQ0])
             & (st.timer01_mode_select[`MS_SRC0] ? fall[`PIN_EV0] : tick);
      r0 = step(mode0, st.tmr0_low_byte, st.tmr0_high_byte, inc0);
      if (mode0 == `MODE_SPLIT) begin
         {set_tf0, next_st.tmr0_low_byte} = {1'b0, st.tmr0_low_byte} + {8'h00, inc0};
         {split_carry, next_st.tmr0_high_byte} = {1'b0, st.tmr0_high_byte}
                                                + {8'h00, st.tmr1_run & tick};
      end else begin
         next_st.tmr0_low_byte = r0.low;
         next_st.tmr0_high_byte = r0.high;
         set_tf0 = r0.ovf;
      end

      // Timer 1; its own mode 3 simply removes the count enable
      mode1 = st.timer01_mode_select[`MS_MODE1];
      inc1 = st.tmr1_run & (~st.timer01_mode_select[`MS_GATE1] | st.level[`PIN_IRQ1])
             & (mode1 != `MODE_SPLIT)
             & (st.timer01_mode_select[`MS_SRC1] ? fall[`PIN_EV1] : tick);
      r1 = step(mode1, st.tmr1_low_byte, st.tmr1_high_byte, inc1);
      next_st.tmr1_low_byte = r1.low;
      next_st.tmr1_high_byte = r1.high;
      t1_ovf = r1.ovf;
      // While timer 0 is split its high byte owns the flag; timer 1 still feeds baud
      set_tf1 = (mode0 == `MODE_SPLIT) ? split_carry : t1_ovf;

      // Timer 2
      t2c = st.timer2_control;
      baud_mode = t2c[`TC_RXCLK] | t2c[`TC_TXCLK] | (|st.power_control_reg);
      inc2 = t2c[`TC_RUN] & (t2c[`TC_SRC] ? fall[`PIN_EV2] : tick);
      ovf2 = inc2 & (st.tmr2_count == `WORD_FULL);
      trig = fall[`PIN_TRIG] & t2c[`TC_EXEN] & t2c[`TC_RUN];
      if (ovf2) begin
         next_st.tmr2_count = (baud_mode | ~t2c[`TC_CPRL]) ? st.tmr2_capture : 16'h0000;
      end else begin
         next_st.tmr2_count = st.tmr2_count + {15'h0, inc2};
      end
      if (trig & ~baud_mode) begin
         if (t2c[`TC_CPRL]) begin
            next_st.tmr2_capture = st.tmr2_count;
         end else begin
            next_st.tmr2_count = st.tmr2_capture;
         end
      end
      next_st.baud[`BAUD_U1RX] = t2c[`TC_RXCLK] ? ovf2 : t1_ovf;
      next_st.baud[`BAUD_U1TX] = t2c[`TC_TXCLK] ? ovf2 : t1_ovf;
      next_st.baud[`BAUD_U2RX] = st.power_control_reg[`PC_RX2] ? ovf2 : t1_ovf;
      next_st.baud[`BAUD_U2TX] = st.power_control_reg[`PC_TX2] ? ovf2 : t1_ovf;

      // Register writes: address and data are taken together
      sw_wr = awvalid & wvalid & ~st.bvalid & ~st.awready;
      if (sw_wr) begin
         next_st.awready = 1'b1;
         next_st.wready = 1'b1;
         next_st.bresp = `RESP_OKAY;
         case (awaddr)
            `OFF_MODE: if (wstrb[0]) next_st.timer01_mode_select = wdata[7:0];
            `OFF_RUN: if (wstrb[0]) begin
               {next_st.tmr1_overflow_flag, next_st.tmr0_overflow_flag} = wdata[3:2];
               {next_st.tmr1_run, next_st.tmr0_run} = wdata[1:0];
            end
            `OFF_TMR0: begin
               if (wstrb[0]) next_st.tmr0_low_byte = wdata[7:0];
               if (wstrb[1]) next_st.tmr0_high_byte = wdata[15:8];
            end
            `OFF_TMR1: begin
               if (wstrb[0]) next_st.tmr1_low_byte = wdata[7:0];
               if (wstrb[1]) next_st.tmr1_high_byte = wdata[15:8];
            end
            `OFF_T2CTL: if (wstrb[0]) next_st.timer2_control = wdata[7:0];
            `OFF_TMR2: begin
               if (wstrb[0]) next_st.tmr2_count[7:0] = wdata[7:0];
               if (wstrb[1]) next_st.tmr2_count[15:8] = wdata[15:8];
            end
            `OFF_CAP: begin
               if (wstrb[0]) next_st.tmr2_capture[7:0] = wdata[7:0];
               if (wstrb[1]) next_st.tmr2_capture[15:8] = wdata[15:8];
            end
            `OFF_POWER_CONTROL_REG: if (wstrb[0]) next_st.power_control_reg = wdata[1:0];
            default: next_st.bresp = `RESP_SLVERR;
         endcase
      end
      if (st.awready) begin
         next_st.bvalid = 1'b1;
      end else if (st.bvalid & bready) begin
         next_st.bvalid = 1'b0;
      end

      // Hardware sets win over any clear in the same cycle
      next_st.tmr0_overflow_flag = (next_st.tmr0_overflow_flag & ~tmr0_vector_ack) | set_tf0;
      next_st.tmr1_overflow_flag = (next_st.tmr1_overflow_flag & ~tmr1_vector_ack) | set_tf1;
      next_st.timer2_control[`TC_OVF] = next_st.timer2_control[`TC_OVF] | (ovf2 & ~baud_mode);
      next_st.timer2_control[`TC_EXT] = next_st.timer2_control[`TC_EXT] | trig;
      next_st.tmr2_irq = next_st.timer2_control[`TC_OVF] | next_st.timer2_control[`TC_EXT];

      // Register reads sample the state in the cycle the address is taken
      sw_rd = arvalid & ~st.rvalid & ~st.arready;
      if (sw_rd) begin
         next_st.arready = 1'b1;
         next_st.rresp = `RESP_OKAY;
         case (araddr)
            `OFF_MODE: next_st.rdata = {24'h000000, st.timer01_mode_select};
            `OFF_RUN: next_st.rdata = {28'h0000000, st.tmr1_overflow_flag, st.tmr0_overflow_flag,
                                       st.tmr1_run, st.tmr0_run};
            `OFF_TMR0: next_st.rdata = {16'h0000, st.tmr0_high_byte, st.tmr0_low_byte};
            `OFF_TMR1: next_st.rdata = {16'h0000, st.tmr1_high_byte, st.tmr1_low_byte};
            `OFF_T2CTL: next_st.rdata = {24'h000000, st.timer2_control};
            `OFF_TMR2: next_st.rdata = {16'h0000, st.tmr2_count};
            `OFF_CAP: next_st.rdata = {16'h0000, st.tmr2_capture};
            `OFF_POWER_CONTROL_REG: next_st.rdata = {30'h0, st.power_control_reg};
            default: begin
               next_st.rdata = 32'h00000000;
               next_st.rresp = `RESP_SLVERR;
            end
         endcase
      end
      if (st.arready) begin
         next_st.rvalid = 1'b1;
      end else if (st.rvalid & rready) begin
         next_st.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign awready = st.awready;
   assign wready = st.wready;
   assign bvalid = st.bvalid;
   assign bresp = st.bresp;
   assign arready = st.arready;
   assign rvalid = st.rvalid;
   assign rdata = st.rdata;
   assign rresp = st.rresp;
   assign tmr0_overflow_flag = st.tmr0_overflow_flag;
   assign tmr1_overflow_flag = st.tmr1_overflow_flag;
   assign tmr2_irq = st.tmr2_irq;
   assign uart1_rx_baud = st.baud[`BAUD_U1RX];
   assign uart1_tx_baud = st.baud[`BAUD_U1TX];
   assign uart2_rx_baud = st.baud[`BAUD_U2RX];
   assign uart2_tx_baud = st.baud[`BAUD_U2TX];

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_prescale_wrap: assert property (tick |=> st.prescale == 4'h0 ##11 tick)
      else $error("machine cycle is not twelve clocks");
   a_gate_blocks: assert property (
      st.timer01_mode_select[`MS_GATE0] && !st.level[`PIN_IRQ0] && mode0 != `MODE_SPLIT
      && !sw_wr |=> $stable({st.tmr0_high_byte, st.tmr0_low_byte}))
      else $error("gated timer 0 counted with irq pin low");
   a_source_count: assert property (
      mode0 == `MODE_16BIT && st.timer01_mode_select[`MS_SRC0] && !fall[`PIN_EV0] && !sw_wr
      |=> $stable({st.tmr0_high_byte, st.tmr0_low_byte}))
      else $error("event counter moved without a pin edge");
   a_cascade_count: assert property (
      mode0 == `MODE_16BIT && inc0 && !sw_wr
      |=> {st.tmr0_high_byte, st.tmr0_low_byte}
          == $past({st.tmr0_high_byte, st.tmr0_low_byte}) + 16'h0001)
      else $error("16-bit count did not step by one");
   a_prescale_carry: assert property (
      mode0 == `MODE_13BIT && inc0 && !sw_wr
      && st.tmr0_low_byte[`PRESC_MSB:0] == `PRESC_FULL && st.tmr0_high_byte != `BYTE_FULL
      |=> st.tmr0_high_byte == $past(st.tmr0_high_byte) + 8'h01
          && st.tmr0_low_byte[`PRESC_MSB:0] == 5'h00)
      else $error("13-bit prescaler carry wrong");
   // Timer 1 is the one that runs in reload mode, both with and without the split
   a_byte_reload: assert property (
      mode1 == `MODE_RELOAD8 && inc1 && !sw_wr && st.tmr1_low_byte == `BYTE_FULL
      |=> st.tmr1_low_byte == $past(st.tmr1_high_byte) && $stable(st.tmr1_high_byte))
      else $error("8-bit reload wrong");
   a_reload_flag: assert property (
      mode1 == `MODE_RELOAD8 && mode0 != `MODE_SPLIT && inc1 && st.tmr1_low_byte == `BYTE_FULL
      |=> st.tmr1_overflow_flag)
      else $error("8-bit reload flag missing");
   a_tmr1_freeze: assert property (mode1 == `MODE_SPLIT && !sw_wr
      |=> $stable({st.tmr1_high_byte, st.tmr1_low_byte}))
      else $error("timer 1 moved in mode 3");
   a_split_high: assert property (
      mode0 == `MODE_SPLIT && st.tmr1_run && tick && !sw_wr
      |=> st.tmr0_high_byte == $past(st.tmr0_high_byte) + 8'h01)
      else $error("split high byte missed a machine cycle");
   // The split takes timer 1's flag, yet its overflow must still reach the serial ports
   a_split_baud: assert property (
      mode0 == `MODE_SPLIT && t1_ovf && !t2c[`TC_RXCLK] |=> uart1_rx_baud)
      else $error("timer 1 baud pulse lost during split");
   a_split_flag: assert property (
      mode0 == `MODE_SPLIT && !split_carry && !sw_wr
      && !st.tmr1_overflow_flag |=> !st.tmr1_overflow_flag)
      else $error("timer 1 overflow set its flag during split");
   a_t2_stopped: assert property (!t2c[`TC_RUN] && !sw_wr |=> $stable(st.tmr2_count))
      else $error("timer 2 moved while stopped");
   a_capture_edge: assert property (
      trig && !baud_mode && t2c[`TC_CPRL] && !sw_wr
      |=> st.tmr2_capture == $past(st.tmr2_count) && st.timer2_control[`TC_EXT]
          ##1 st.tmr2_irq)
      else $error("capture edge lost");
   a_trigger_reload: assert property (
      trig && !baud_mode && !t2c[`TC_CPRL] && !sw_wr
      |=> st.tmr2_count == $past(st.tmr2_capture) && st.timer2_control[`TC_EXT])
      else $error("reload edge lost");
   a_baud_trigger: assert property (
      trig && baud_mode && !sw_wr
      |=> $stable(st.tmr2_capture) && st.timer2_control[`TC_EXT])
      else $error("trigger in baud mode did more than flag");
   a_ext_flag_hold: assert property (
      st.timer2_control[`TC_EXT] && !sw_wr |=> st.timer2_control[`TC_EXT])
      else $error("timer 2 external flag cleared by hardware");
   a_baud_no_flag: assert property (
      baud_mode && !st.timer2_control[`TC_OVF] && !sw_wr |=> !st.timer2_control[`TC_OVF])
      else $error("timer 2 flag set in baud mode");
   a_baud_reload: assert property (ovf2 && baud_mode && !sw_wr
      |=> st.tmr2_count == $past(st.tmr2_capture))
      else $error("baud mode overflow did not reload");
   a_vector_clear: assert property (
      tmr0_vector_ack && !set_tf0 && !sw_wr |=> !st.tmr0_overflow_flag)
      else $error("vector acknowledge did not clear timer 0 flag");
   a_write_answer: assert property (sw_wr |=> awready && wready ##1 bvalid)
      else $error("write answer out of order");

   c_capture: cover property (trig && t2c[`TC_CPRL] && !baud_mode);
   c_split_flag: cover property (mode0 == `MODE_SPLIT && split_carry);
   c_baud_tick: cover property (st.baud[`BAUD_U1RX] && baud_mode);
   c_read_back: cover property (st.rvalid && rready);
endmodule : three_timer_counter_unit

// ===== timer_unit_map.svh
// Register map, field positions and counts for the three timer/counter unit
// Notes on behaviour
// - Mode 1 cascades both bytes, no prescaler
// - Gate set: count needs irq pin high and run
// - Select bit picks machine cycles or event pin
// - Mode field: 13-bit, 16-bit, 8-bit reload, split
// - Low byte overflow reloads from high byte
// - Timer 1 mode 3 freezes its count
// - Timer 0 mode 3: two 8-bit counters
// - Timer 1 runs flagless while timer 0 splits
// - Timer 2 source: machine cycles or event falls
// - Capture mode: 16-bit up count sets overflow
// - Trigger fall captures count, sets external flag
// - Reload mode: rollover reloads from capture pair
// - Trigger fall also reloads in reload mode
// - Any baud select forces reload on overflow
// - No overflow flag while clocking serial port
// - Baud mode trigger only sets external flag
// - Port 1 baud from timer 2 or 1
// - Power control bits steer port 2 baud
// - Timer 2 run bit starts and stops it
// - Internal /12, events at most /24 oscillator
// - Timer 2 flags request interrupt, software clears
// - Timer increments once per twelve clocks
// - Pin edge: high sample then low sample
// - Timer 0/1 flags cleared on vector acknowledge
`ifndef TIMER_UNIT_MAP_SVH
`define TIMER_UNIT_MAP_SVH
`define OFF_MODE 8'h00
`define OFF_RUN 8'h04
`define OFF_TMR0 8'h08
`define OFF_TMR1 8'h0c
`define OFF_T2CTL 8'h10
`define OFF_TMR2 8'h14
`define OFF_CAP 8'h18
`define OFF_POWER_CONTROL_REG 8'h1c
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define MC_LAST 4'hb
`define MS_GATE1 7
`define MS_SRC1 6
`define MS_MODE1 5:4
`define MS_GATE0 3
`define MS_SRC0 2
`define MS_MODE0 1:0
`define MODE_13BIT 2'h0
`define MODE_16BIT 2'h1
`define MODE_RELOAD8 2'h2
`define MODE_SPLIT 2'h3
`define PRESC_MSB 4
`define PRESC_FULL 5'h1f
`define BYTE_FULL 8'hff
`define WORD_FULL 16'hffff
`define TC_OVF 7
`define TC_EXT 6
`define TC_RXCLK 5
`define TC_TXCLK 4
`define TC_EXEN 3
`define TC_RUN 2
`define TC_SRC 1
`define TC_CPRL 0
`define PC_RX2 0
`define PC_TX2 1
`define PIN_IRQ0 0
`define PIN_IRQ1 1
`define PIN_EV0 2
`define PIN_EV1 3
`define PIN_EV2 4
`define PIN_TRIG 5
`define NPINS 6
`define BAUD_U1RX 0
`define BAUD_U1TX 1
`define BAUD_U2RX 2
`define BAUD_U2TX 3
`endif

// ===== timer_unit_pkg.sv
// Types shared by the three timer/counter unit
package timer_unit_pkg;
   typedef struct packed {
      logic [7:0] low;
      logic [7:0] high;
      logic ovf;
   } step_t;

   typedef struct packed {
      logic [5:0] sync1;
      logic [5:0] sync2;
      logic [5:0] sync3;
      logic [5:0] level;
      logic [5:0] sample;
      logic [3:0] prescale;
      logic [7:0] timer01_mode_select;
      logic [7:0] timer2_control;
      logic [1:0] power_control_reg;
      logic tmr0_run;
      logic tmr1_run;
      logic tmr0_overflow_flag;
      logic tmr1_overflow_flag;
      logic [7:0] tmr0_low_byte;
      logic [7:0] tmr0_high_byte;
      logic [7:0] tmr1_low_byte;
      logic [7:0] tmr1_high_byte;
      logic [15:0] tmr2_count;
      logic [15:0] tmr2_capture;
      logic tmr2_irq;
      logic [3:0] baud;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;
endpackage : timer_unit_pkg
